/* File: design/fps_pkg.sv */
// Function
// - soft-start ramps current limit over 8ms
// - sense short auto-restart; overvolt, thermal latch
// - overload fault mode chosen at build time
// - auto fault: gate off, clear at 11V
// - auto: charger on at 7V, run at 17V
// - latched: charge at 7V, stop at 17V
// - latched fault clears only below 4V
// - supply above 24.5V raises overvolt fault
// - thermistor below 1.035V over 14.5ms latches
// - thermistor below 0.7V over 185us latches
// - feedback above 4.6V over 57.5ms faults
// - sample sense 4.55us after gate on
// - eleven low samples in a row fault
// - short threshold tracks line, 50 to 100mV
// - no fault: stop only below 6.5V
// - fault: stop below 11V, low current to 7V
// - current limit falls as line peak rises
//==============================================================
// fault protection supervisor constants
package fps_pkg;
	// clock period
	localparam int CLK_NS            = 50;
	// printed times and derived cycle counts
	localparam int SOFTSTART_NS      = 8_000_000;
	localparam int SOFTSTART_CYC     = (SOFTSTART_NS + CLK_NS - 1) / CLK_NS;
	localparam int THERMAL_DELAY_NS  = 14_500_000;
	localparam int THERMAL_DELAY_CYC =
		(THERMAL_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int EXT_TRIP_DELAY_NS = 185_000;
	localparam int EXT_TRIP_DELAY_CYC =
		(EXT_TRIP_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int OVERLOAD_DELAY_NS = 57_500_000;
	localparam int OVERLOAD_DELAY_CYC =
		(OVERLOAD_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int SHORT_SAMPLE_NS   = 4_550;
	localparam int SHORT_SAMPLE_CYC  =
		(SHORT_SAMPLE_NS + CLK_NS - 1) / CLK_NS;
	// consecutive low samples before a sense short fault
	localparam int SHORT_COUNT       = 11;
	// short threshold in mV at low and high line
	localparam logic [7:0] SHORT_THR_LOW_MV  = 8'h32;
	localparam logic [7:0] SHORT_THR_HIGH_MV = 8'h64;
	// current limit code at zero line, halved line slope
	localparam logic [7:0] LIMIT_BASE        = 8'hFF;
	// register offsets
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_MASK   = 4'h4;
	localparam logic [3:0] OFS_STATE  = 4'h8;
	// fault bit positions
	localparam int BIT_OVERLOAD = 0;
	localparam int BIT_OVERVOLT = 1;
	localparam int BIT_THERMAL  = 2;
	localparam int BIT_EXTTRIP  = 3;
	localparam int BIT_SHORT    = 4;
	localparam int NUM_FAULTS   = 5;
	// reset values
	localparam logic [4:0] MASK_RESET = 5'h00;
	// supervisor states
	typedef enum logic [2:0] {
		ST_CHARGE,   // start-up charger on, waiting for 17V
		ST_RUN,      // switching
		ST_FAULT_HI, // fault, gate off, waiting for 11V
		ST_FAULT_LO  // reduced current, waiting for 7V
	} fps_state_t;
endpackage : fps_pkg

/* File: design/fps_supervisor.sv */
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// fault protection and restart supervisor
module fps_supervisor #(
	parameter bit OVERLOAD_LATCHES = 1'b0,
	parameter int SOFTSTART_CYC    = fps_pkg::SOFTSTART_CYC,
	parameter int THERMAL_CYC      = fps_pkg::THERMAL_DELAY_CYC,
	parameter int OVERLOAD_CYC     = fps_pkg::OVERLOAD_DELAY_CYC
) (
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_sys_rst,
	// supply rail comparators
	input  wire logic       i_vdd_above_ovp,
	input  wire logic       i_vdd_above_on,
	input  wire logic       i_vdd_below_off,
	input  wire logic       i_vdd_below_restart,
	input  wire logic       i_vdd_below_lockout,
	input  wire logic       i_vdd_below_clear,
	// pin comparators
	input  wire logic       i_thermal_low,
	input  wire logic       i_ext_trip_low,
	input  wire logic       i_overload_feedback,
	input  wire logic       i_sense_below_short,
	// modulator and line sense
	input  wire logic       i_pwm_gate,
	input  wire logic [7:0] i_line_peak,
	// register port
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rd_data,
	// power stage controls
	output logic            o_gate,
	output logic            o_hv_start_en,
	output logic            o_reduced_supply_current,
	output logic      [7:0] o_current_limit_level,
	output logic      [7:0] o_short_detect_threshold,
	output logic            o_fault_active,
	output logic            o_irq
);
	localparam int NSYNC = 11;
	localparam int STEP_CYC = (SOFTSTART_CYC / 256 < 1) ? 1
		: SOFTSTART_CYC / 256;
	// one ramp step per STEP_CYC cycles gives 255 steps over the
	// whole soft-start time; a very short ramp still moves one code
	// per cycle so the limit never stalls at zero
	// NSYNC is the number of comparator and modulator gate lines brought into the clock

	//==========================================================
	// comparator synchronisers
	logic [NSYNC-1:0] async_in;    // raw comparator levels
	logic [NSYNC-1:0] sync_a_reg;  // first stage, second stage only
	logic [NSYNC-1:0] sync_b_reg;  // usable levels
	assign async_in = {i_vdd_above_ovp, i_vdd_above_on, i_vdd_below_off,
		i_vdd_below_restart, i_vdd_below_lockout, i_vdd_below_clear,
		i_thermal_low, i_ext_trip_low, i_overload_feedback,
		i_sense_below_short, i_pwm_gate};
	// comparator edges are unrelated to the clock, so each level
	// passes two flops; only the second flop is ever read, which
	// keeps a metastable first stage away from the control logic
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			// two flops per comparator
			always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					sync_a_reg[gi] <= 1'b0;
					sync_b_reg[gi] <= 1'b0;
				end else begin
					sync_a_reg[gi] <= async_in[gi];
					sync_b_reg[gi] <= sync_a_reg[gi];
				end
			end
		end
	endgenerate
	logic supply_overvolt_fault, v_on, v_off, v_rst, v_lock, v_clr;
	logic th_low, ext_low, fb_hi, cs_low, pwm;
	assign {supply_overvolt_fault, v_on, v_off, v_rst, v_lock, v_clr,
		th_low, ext_low, fb_hi, cs_low, pwm} = sync_b_reg;

	//==========================================================
	// state and fault holding
	fps_pkg::fps_state_t state_reg;
	logic auto_fault_reg;   // cleared at 11V
	logic latch_fault_reg;  // cleared at 4V
	logic [4:0] evt;        // one-cycle fault events
	logic auto_evt, latch_evt;
	logic ovl_latch;
	assign ovl_latch = OVERLOAD_LATCHES;
	assign auto_evt  = evt[fps_pkg::BIT_SHORT] |
		(evt[fps_pkg::BIT_OVERLOAD] & ~ovl_latch);
	assign latch_evt = evt[fps_pkg::BIT_OVERVOLT] |
		evt[fps_pkg::BIT_THERMAL] | evt[fps_pkg::BIT_EXTTRIP] |
		(evt[fps_pkg::BIT_OVERLOAD] & ovl_latch);
	logic fault_any;
	assign fault_any = auto_fault_reg | latch_fault_reg;

	// a fault event in the same cycle as the clearing level wins,
	// so a cause that is still present is never silently dropped
	// while the rail passes the clearing threshold
	// auto-restart fault, set wins over clear
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			auto_fault_reg <= 1'b0;
		end else if (auto_evt) begin
			auto_fault_reg <= 1'b1;
		end else if (state_reg == fps_pkg::ST_FAULT_HI && v_off) begin
			auto_fault_reg <= 1'b0;
		end
	end

	// latched fault, only the 4V level clears it
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			latch_fault_reg <= 1'b0;
		end else if (latch_evt) begin
			latch_fault_reg <= 1'b1;
		end else if (v_clr) begin
			latch_fault_reg <= 1'b0;
		end
	end

	// the sequencer follows the rail: charge up to the turn-on level,
	// run until a fault or lockout, then with a fault hold the gate
	// off, drop to reduced current below the raised off level and
	// charge again from the restart level
	// restart sequencer
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_reg <= fps_pkg::ST_CHARGE;
		end else begin
			case (state_reg)
				fps_pkg::ST_CHARGE: begin
					// at 17V run, or stop charging if latched
					if (v_on && !latch_fault_reg && !auto_fault_reg) begin
						state_reg <= fps_pkg::ST_RUN;
					end else if (v_on) begin
						state_reg <= fps_pkg::ST_FAULT_HI;
					end
				end
				fps_pkg::ST_RUN: begin
					if (fault_any || auto_evt || latch_evt) begin
						state_reg <= fps_pkg::ST_FAULT_HI;
					end else if (v_lock) begin
						state_reg <= fps_pkg::ST_CHARGE;
					end
				end
				fps_pkg::ST_FAULT_HI: begin
					// raised turn-off level while faulted
					if (v_off) begin
						state_reg <= fps_pkg::ST_FAULT_LO;
					end
				end
				fps_pkg::ST_FAULT_LO: begin
					// reduced current until restart level
					if (v_rst) begin
						state_reg <= fps_pkg::ST_CHARGE;
					end
				end
				default: begin
					state_reg <= fps_pkg::ST_CHARGE;
				end
			endcase
		end
	end

	//==========================================================
	// delay timers, each restarts when its condition drops
	logic [31:0] th_cnt_reg, ext_cnt_reg, ol_cnt_reg;
	logic        running;
	assign running = (state_reg == fps_pkg::ST_RUN);

	// the counters keep running while the level stays, but the event
	// compares for equality, so each held condition fires only once;
	// any dropout of the level starts the count again from zero
	// thermal and external trip timers
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			th_cnt_reg  <= 32'h0000_0000;
			ext_cnt_reg <= 32'h0000_0000;
		end else begin
			th_cnt_reg  <= th_low ? th_cnt_reg + 32'h0000_0001
				: 32'h0000_0000;
			ext_cnt_reg <= ext_low ? ext_cnt_reg + 32'h0000_0001
				: 32'h0000_0000;
		end
	end

	// overload timer counts only while switching
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ol_cnt_reg <= 32'h0000_0000;
		end else begin
			ol_cnt_reg <= (fb_hi && running) ? ol_cnt_reg + 32'h0000_0001
				: 32'h0000_0000;
		end
	end

	// overvolt has no delay: it fires while the rail is high and
	// no latched fault is held yet, so a long excursion raises
	// the status bit once per latch episode
	// events fire once when the time is exceeded
	assign evt[fps_pkg::BIT_THERMAL]  =
		(th_cnt_reg == 32'(THERMAL_CYC));
	assign evt[fps_pkg::BIT_EXTTRIP]  =
		(ext_cnt_reg == 32'(fps_pkg::EXT_TRIP_DELAY_CYC));
	assign evt[fps_pkg::BIT_OVERLOAD] =
		(ol_cnt_reg == 32'(OVERLOAD_CYC));
	assign evt[fps_pkg::BIT_OVERVOLT] = supply_overvolt_fault & ~latch_fault_reg;

	//==========================================================
	// sense short detection
	logic       gate_q_reg;   // previous gate
	logic [7:0] smp_cnt_reg;  // cycles since gate on
	logic       smp_arm_reg;  // sample pending
	logic [3:0] low_cnt_reg;  // consecutive low samples
	logic       smp_now;
	assign smp_now = smp_arm_reg && o_gate &&
		(smp_cnt_reg == 8'(fps_pkg::SHORT_SAMPLE_CYC));

	// the sense line is looked at a fixed time after each gate rise;
	// a gate pulse shorter than that gives no sample at all, so a
	// narrow duty cycle neither counts nor resets the low run
	// gate-on timer for the sample point
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gate_q_reg  <= 1'b0;
			smp_cnt_reg <= 8'h00;
			smp_arm_reg <= 1'b0;
		end else begin
			gate_q_reg <= o_gate;
			if (o_gate && !gate_q_reg) begin
				smp_cnt_reg <= 8'h01;
				smp_arm_reg <= 1'b1;
			end else if (!o_gate || smp_now) begin
				smp_arm_reg <= 1'b0;
			end else begin
				smp_cnt_reg <= smp_cnt_reg + 8'h01;
			end
		end
	end

	// run of low samples
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			low_cnt_reg <= 4'h0;
		end else if (!running) begin
			low_cnt_reg <= 4'h0;
		end else if (smp_now) begin
			low_cnt_reg <= cs_low ? low_cnt_reg + 4'h1 : 4'h0;
		end
	end
	assign evt[fps_pkg::BIT_SHORT] = smp_now && cs_low &&
		(low_cnt_reg == 4'(fps_pkg::SHORT_COUNT - 1));

	//==========================================================
	// soft-start ramp and line compensation
	logic [31:0] ss_cnt_reg;   // cycles within one ramp step
	logic [7:0]  ramp_reg;     // ramped limit
	logic [7:0]  line_lim;     // line compensated limit
	logic [7:0]  thr_mv;       // short threshold in mV
	assign line_lim = fps_pkg::LIMIT_BASE - {1'b0, i_line_peak[7:1]};
	assign thr_mv = fps_pkg::SHORT_THR_LOW_MV + 8'(({8'h00, i_line_peak}
		* 16'(fps_pkg::SHORT_THR_HIGH_MV - fps_pkg::SHORT_THR_LOW_MV))
		>> 8);

	// the ramp starts from zero on every entry into run, so each
	// restart after a fault gets the full soft-start again; the
	// output is the lower of the ramp and the line limit
	// ramp restarts whenever switching is not running
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ss_cnt_reg <= 32'h0000_0000;
			ramp_reg   <= 8'h00;
		end else if (!running) begin
			ss_cnt_reg <= 32'h0000_0000;
			ramp_reg   <= 8'h00;
		end else if (ramp_reg != 8'hFF) begin
			if (ss_cnt_reg == 32'(STEP_CYC - 1)) begin
				ss_cnt_reg <= 32'h0000_0000;
				ramp_reg   <= ramp_reg + 8'h01;
			end else begin
				ss_cnt_reg <= ss_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// limit and threshold outputs
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_current_limit_level    <= 8'h00;
			o_short_detect_threshold <= fps_pkg::SHORT_THR_LOW_MV;
		end else begin
			o_current_limit_level <= (ramp_reg < line_lim) ? ramp_reg
				: line_lim;
			o_short_detect_threshold <= thr_mv;
		end
	end

	//==========================================================
	// power stage drive
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_gate                   <= 1'b0;
			o_hv_start_en            <= 1'b1;
			o_reduced_supply_current <= 1'b0;
			o_fault_active           <= 1'b0;
		end else begin
			o_gate <= pwm && running && !fault_any &&
				!auto_evt && !latch_evt;
			o_hv_start_en <= (state_reg == fps_pkg::ST_CHARGE) &&
				!v_on;
			o_reduced_supply_current <=
				(state_reg == fps_pkg::ST_FAULT_LO);
			o_fault_active <= fault_any;
		end
	end

	//==========================================================
	// status, mask, interrupt and read port
	logic [4:0] status_reg;
	logic [4:0] mask_reg;
	logic [4:0] w1c;
	assign w1c = (i_wr && i_addr == fps_pkg::OFS_STATUS)
		? i_wr_data[4:0] : 5'h00;

	// a write of one clears a bit, but an event arriving in the same
	// cycle keeps it set so software cannot lose a fresh fault
	// sticky status, set wins over clear
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			status_reg <= 5'h00;
		end else begin
			status_reg <= (status_reg & ~w1c) | evt;
		end
	end

	// mask register
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mask_reg <= fps_pkg::MASK_RESET;
		end else if (i_wr && i_addr == fps_pkg::OFS_MASK) begin
			mask_reg <= i_wr_data[4:0];
		end
	end

	// interrupt level
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(status_reg & mask_reg);
		end
	end

	// reads have no side effects; the data bus returns to zero
	// between reads so a stale value is never mistaken for fresh
	// read data valid only in the cycle after the strobe
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rd_data <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				fps_pkg::OFS_STATUS: o_rd_data <= {3'b000, status_reg};
				fps_pkg::OFS_MASK:   o_rd_data <= {3'b000, mask_reg};
				fps_pkg::OFS_STATE:  o_rd_data <= {2'b00,
					latch_fault_reg, auto_fault_reg, o_gate,
					state_reg};
				default:             o_rd_data <= 8'h00;
			endcase
		end else begin
			o_rd_data <= 8'h00;
		end
	end
endmodule : fps_supervisor
`default_nettype wire

/* File: bench/fps_supervisor_props.sv */
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// port checker for the protection supervisor
module fps_supervisor_props #(
	parameter int SOFTSTART_CYC = 512, // ramp length in cycles
	parameter int THERMAL_CYC   = 50,  // thermal hold in cycles
	parameter int OVERLOAD_CYC  = 60   // overload hold in cycles
) (
	// clock and reset
	input wire logic       i_core_clk,
	input wire logic       i_sys_rst,
	// watched inputs
	input wire logic       i_vdd_above_ovp,
	input wire logic       i_vdd_above_on,
	input wire logic       i_vdd_below_off,
	input wire logic       i_vdd_below_restart,
	input wire logic       i_pwm_gate,
	input wire logic [7:0] i_line_peak,
	// watched outputs
	input wire logic       o_gate,
	input wire logic       o_hv_start_en,
	input wire logic       o_reduced_supply_current,
	input wire logic [7:0] o_current_limit_level,
	input wire logic [7:0] o_short_detect_threshold,
	input wire logic       o_fault_active
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	// gate held off for a stretch
	sequence s_gate_quiet;
		!o_gate [*8];
	endsequence
	// stable line for long enough to reach the outputs
	sequence s_line_steady;
		i_line_peak == $past(i_line_peak, 4);
	endsequence
	chk_fault_quiet: assert property (
		$rose(o_fault_active) |-> s_gate_quiet)
		else $error("gate switched right after a fault");
	chk_fault_gate_off: assert property (
		o_fault_active && $past(o_fault_active) |-> !o_gate)
		else $error("gate on while a fault is held");
	chk_gate_follow: assert property (
		o_gate |-> $past(i_pwm_gate, 3))
		else $error("gate on without a modulator request");
	chk_hv_on_level: assert property (
		o_hv_start_en && i_vdd_above_on |-> ##[1:4] !o_hv_start_en)
		else $error("charger still on above turn-on level");
	chk_hv_restart: assert property (
		$rose(o_hv_start_en) |-> $past(i_vdd_below_restart, 3) ||
		$past(i_vdd_below_restart, 4))
		else $error("charger on above the restart level");
	chk_reduced_idle: assert property (
		o_reduced_supply_current |-> !o_gate && !o_hv_start_en)
		else $error("reduced current state while active");
	chk_ovp_trip: assert property (
		$rose(i_vdd_above_ovp) |-> ##[1:4] o_fault_active)
		else $error("overvoltage did not raise a fault");
	chk_fault_release: assert property (
		$fell(o_fault_active) |-> $past(i_vdd_below_off, 4))
		else $error("fault cleared above the off level");
	chk_ramp_step: assert property (
		s_line_steady ##0
		o_current_limit_level > $past(o_current_limit_level) |->
		o_current_limit_level == $past(o_current_limit_level) + 8'h01)
		else $error("current limit jumped during the ramp");
	chk_thr_line: assert property (
		s_line_steady |-> o_short_detect_threshold ==
		8'(32'd50 + (32'(i_line_peak) * 32'd50) / 32'd256))
		else $error("short threshold off the line slope");
endmodule : fps_supervisor_props

bind fps_supervisor fps_supervisor_props #(
	.SOFTSTART_CYC(SOFTSTART_CYC), .THERMAL_CYC(THERMAL_CYC),
	.OVERLOAD_CYC(OVERLOAD_CYC)) fps_supervisor_props_inst (
	.i_core_clk, .i_sys_rst, .i_vdd_above_ovp, .i_vdd_above_on,
	.i_vdd_below_off, .i_vdd_below_restart, .i_pwm_gate, .i_line_peak,
	.o_gate, .o_hv_start_en, .o_reduced_supply_current,
	.o_current_limit_level, .o_short_detect_threshold, .o_fault_active);
`default_nettype wire

/* File: bench/fps_power_stage.sv */
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// power stage: hold-up rail in 0.1V steps and comparators
module fps_power_stage (
	// drive from the supervisor
	input  wire logic       i_core_clk,
	input  wire logic       i_gate,
	input  wire logic       i_hv_en,
	// aux mode (1 hold, 2 overdrive), line present, shorted sense
	input  wire logic [1:0] i_aux,
	input  wire logic       i_line_on,
	input  wire logic       i_sense_short,
	// comparator results
	output logic            o_ovp,
	output logic            o_on,
	output logic            o_off,
	output logic            o_rst,
	output logic            o_lock,
	output logic            o_clr,
	output logic            o_sense_low
);
	int vdd_reg  = 0;  // rail level
	int idle_reg = 64; // cycles since the gate was on
	// charger lifts, aux holds only while switching, else drains
	always @(posedge i_core_clk) begin
		idle_reg <= i_gate ? 0 : (idle_reg < 64 ? idle_reg + 1 : 64);
		if ((i_hv_en && i_line_on) || i_aux == 2'd2)
			vdd_reg <= vdd_reg + 1;
		else if (!(i_aux == 2'd1 && idle_reg < 64) && vdd_reg > 0)
			vdd_reg <= vdd_reg - 1;
	end
	assign o_ovp       = vdd_reg > 245;
	assign o_on        = vdd_reg >= 170;
	assign o_off       = vdd_reg < 110;
	assign o_rst       = vdd_reg <= 70;
	assign o_lock      = vdd_reg < 65;
	assign o_clr       = vdd_reg <= 40;
	// no current with the gate off reads as low sense
	assign o_sense_low = i_sense_short || !i_gate;
endmodule : fps_power_stage
`default_nettype wire

/* File: bench/fps_supervisor_test.sv */
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// supervisor testbench
module fps_supervisor_test;
	logic       i_core_clk  = 1'b0;
	logic       i_sys_rst   = 1'b1;
	logic       i_pwm_gate  = 1'b0;
	logic [7:0] i_line_peak = 8'h00;
	logic [3:0] i_addr      = 4'h0;
	logic [7:0] i_wr_data   = 8'h00;
	logic       i_wr        = 1'b0;
	logic       i_rd        = 1'b0;
	logic       line_on     = 1'b1;  // line input present
	logic [4:0] trips       = 5'h00; // fault causes by index
	logic [6:0] pwm_cnt     = 7'h00; // modulator period counter
	logic [7:0] mask_v      = 8'h00; // mask written
	int         err_count       = 0;
	int         samples_checked = 0;
	int         seed            = 32'hf36e;
	// per cause: first hold, status bit, latching
	int         hold_n [5]  = '{40, 3000, 40, 20, 640};
	logic [7:0] bit_v [5]   = '{8'h04, 8'h08, 8'h01, 8'h02, 8'h10};
	logic       latch_v [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
	wire logic i_vdd_above_ovp, i_vdd_above_on, i_vdd_below_off;
	wire logic i_vdd_below_restart, i_vdd_below_lockout;
	wire logic i_vdd_below_clear, sense_low, o_gate, o_hv_start_en;
	wire logic o_reduced_supply_current, o_fault_active, o_irq;
	wire logic [7:0] o_rd_data, o_current_limit_level;
	wire logic [7:0] o_short_detect_threshold;
	fps_supervisor #(.SOFTSTART_CYC(512), .THERMAL_CYC(50),
		.OVERLOAD_CYC(60), .OVERLOAD_LATCHES(1'b0)) fps_supervisor_inst (
		.i_core_clk, .i_sys_rst, .i_vdd_above_ovp, .i_vdd_above_on,
		.i_vdd_below_off, .i_vdd_below_restart, .i_vdd_below_lockout,
		.i_vdd_below_clear, .i_thermal_low(trips[0]),
		.i_ext_trip_low(trips[1]), .i_overload_feedback(trips[2]),
		.i_sense_below_short(sense_low), .i_pwm_gate, .i_line_peak,
		.i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .o_gate,
		.o_hv_start_en, .o_reduced_supply_current,
		.o_current_limit_level, .o_short_detect_threshold,
		.o_fault_active, .o_irq);
	fps_power_stage fps_power_stage_inst (
		.i_core_clk, .i_gate(o_gate), .i_hv_en(o_hv_start_en),
		.i_aux(trips[3] ? 2'd2 : 2'd1), .i_line_on(line_on),
		.i_sense_short(trips[4]), .o_ovp(i_vdd_above_ovp),
		.o_on(i_vdd_above_on), .o_off(i_vdd_below_off),
		.o_rst(i_vdd_below_restart), .o_lock(i_vdd_below_lockout),
		.o_clr(i_vdd_below_clear), .o_sense_low(sense_low));
	always #25 i_core_clk = ~i_core_clk;
	// modulator: on 100 of every 128 cycles
	always @(posedge i_core_clk) begin
		pwm_cnt <= pwm_cnt + 7'h01;
		i_pwm_gate <= pwm_cnt < 7'd100;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task final_report;
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		@(negedge i_core_clk);
		d = o_rd_data;
	endtask : rd
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr
	// poll the state register, bounded
	task automatic wait_st(input logic [2:0] s);
		logic [7:0] d;
		int n;
		n = 0;
		do begin
			rd(fps_pkg::OFS_STATE, d);
			n++;
		end while (d[2:0] !== s && n < 4000);
		if (d[2:0] !== s) begin
			cmp(d, {5'h00, s});
			final_report();
		end
	endtask : wait_st
	// walk the supply back to switching after a fault
	task automatic recover(input logic latched);
		wait_st(3'd3);
		cmp(o_reduced_supply_current, 1'b1);
		cmp(o_fault_active, latched);
		wait_st(3'd0);
		cmp(o_hv_start_en, 1'b1);
		if (latched) begin
			wait_st(3'd2);
			cmp({o_fault_active, o_hv_start_en}, 8'h02);
			line_on <= 1'b0;
			wait_st(3'd0);
			repeat (80) @(posedge i_core_clk);
			cmp(o_fault_active, 1'b0);
			line_on <= 1'b1;
		end
		wait_st(3'd1);
		cmp(o_current_limit_level < 8'h10, 1'b1);
	endtask : recover
	// short hold once, then a held cause until the fault
	task automatic trip(input int sel);
		logic [7:0] d;
		for (int k = 0; k < 2; k++) begin
			trips[sel] <= 1'b1;
			repeat (hold_n[sel]) @(posedge i_core_clk);
			rd(fps_pkg::OFS_STATUS, d);
			cmp(d, 8'h00);
			trips[sel] <= (k == 1);
			repeat (130) @(posedge i_core_clk);
		end
		wait_st(3'd2);
		cmp(o_gate, 1'b0);
		trips[sel] <= 1'b0;
		rd(fps_pkg::OFS_STATUS, d);
		cmp(d, bit_v[sel]);
		cmp(o_irq, |(bit_v[sel] & mask_v));
		wr(fps_pkg::OFS_STATUS, bit_v[sel]);
		rd(fps_pkg::OFS_STATUS, d);
		cmp({d[6:0], o_irq}, 8'h00);
		recover(latch_v[sel]);
	endtask : trip
	//==============================================================
	// main sequence
	initial begin
		logic [7:0] d;
		int lv;
		repeat (20) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_core_clk);
		cmp({o_gate, o_hv_start_en, o_reduced_supply_current,
			o_fault_active, o_irq}, 8'h08);
		cmp(o_short_detect_threshold, 8'h32);
		mask_v = 8'($random(seed)) & 8'h1F;
		rd(fps_pkg::OFS_MASK, d);
		cmp(d, 8'h00);
		wr(fps_pkg::OFS_MASK, {3'b111, mask_v[4:0]});
		wr(4'hC, 8'hFF);
		rd(fps_pkg::OFS_MASK, d);
		cmp(d, mask_v);
		rd(4'hC, d);
		cmp(d, 8'h00);
		wait_st(3'd1);
		cmp(o_hv_start_en, 1'b0);
		cmp(o_current_limit_level < 8'h10, 1'b1);
		for (int j = 0; j < 3; j++) begin
			lv = (j == 0) ? 0 : (j == 1) ? 255 : ($random(seed) & 255);
			i_line_peak <= 8'(lv);
			repeat (600) @(posedge i_core_clk);
			cmp(o_current_limit_level, 8'(255 - lv / 2));
			cmp(o_short_detect_threshold, 8'(50 + lv * 50 / 256));
		end
		for (int s = 0; s < 5; s++)
			trip(s);
		final_report();
	end
endmodule : fps_supervisor_test
`default_nettype wire
